// >>> inc/sensor_cfg_pkg.sv
// Purpose: shared constants and types of the sensor configuration bank
// Assumes: pointer-addressed byte registers, one core clock and one link clock
// Notes: identification value is a neutral parameter of the top module
package sensor_cfg_pkg;
   // ==========
   // Register pointers and reset values
   localparam logic [7:0] PTR_ALERT_COUNT = 8'h22;
   localparam logic [7:0] PTR_IDEALITY = 8'h23;
   localparam logic [7:0] PTR_FILTER = 8'h24;
   localparam logic [7:0] PTR_MAKER = 8'hFE;
   localparam logic [7:0] RST_ALERT_COUNT = 8'h01;
   localparam logic [7:0] RST_IDEALITY = 8'h00;
   localparam logic [7:0] RST_FILTER = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   // ==========
   // Field positions
   localparam int TIMEOUT_BIT = 7;
   localparam int COUNT_MSB = 3;
   localparam int COUNT_LSB = 1;
   localparam int FILTER_MSB = 1;
   // Writable bits; reserved bits keep their reset value
   localparam logic [7:0] ALERT_COUNT_WMASK = 8'h8E;
   localparam logic [7:0] FILTER_WMASK = 8'h03;
   // ==========
   // Averaging codes and depths
   localparam logic [1:0] AVG_OFF = 2'h0;
   localparam logic [1:0] AVG_FOUR = 2'h1;
   localparam logic [1:0] AVG_EIGHT = 2'h2;
   localparam logic [3:0] DEPTH_FOUR = 4'h4;
   localparam logic [3:0] DEPTH_EIGHT = 4'h8;
   localparam int SHIFT_FOUR = 2;
   localparam int SHIFT_EIGHT = 3;
   // ==========
   // Ideality scaling: result = delta * (BASE + adjust) / BASE
   localparam logic [11:0] IDEALITY_BASE = 12'h828;
   localparam int RECIP_SHIFT = 24;
   localparam logic [12:0] IDEALITY_RECIP = 13'h1F63;
   // ==========
   // Timing
   localparam int CORE_CLK_MHZ = 100;
   localparam int EXCITE_SETTLE_NS = 100;
   localparam int SETTLE_CYCLES = (EXCITE_SETTLE_NS * CORE_CLK_MHZ + 999) / 1000;
   // ==========
   // Types
   typedef struct packed {
      logic write;
      logic [7:0] ptr;
      logic [7:0] wdata;
   } reg_req_s;
   typedef enum logic [2:0] {SEQ_IDLE, SEQ_LOW, SEQ_HIGH, SEQ_SCALE, SEQ_DIV, SEQ_AVG} seq_state_e;
endpackage

// >>> logic/link_reg_bridge.sv
// Purpose: carries register requests from the link clock to the core clock and back
// Assumes: link clock runs while a request is pending
// Notes: toggle handshake; command held stable until the answer returns
`timescale 1ns/1ns
module link_reg_bridge
   import sensor_cfg_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic link_clk,
   input wire logic link_req,
   input wire reg_req_s link_cmd,
   output logic [7:0] link_rdata,
   output logic link_done,
   output logic link_busy,
   output logic core_strobe,
   output reg_req_s core_cmd,
   input wire logic [7:0] core_rdata
);
   // ==========
   // Link domain
   logic lrst_meta, lrst_n, req_tgl, ack_s1, ack_s2, ack_seen;
   logic next_req_tgl, next_busy, next_done, next_ack_seen;
   logic [7:0] next_link_rdata;
   reg_req_s held, next_held;
   logic ack_tgl, req_s1, req_s2, req_seen, capture;
   logic [7:0] rdata_hold;

   always_comb begin
      next_req_tgl = req_tgl;
      next_busy = link_busy;
      next_held = held;
      next_done = 1'b0;
      next_ack_seen = ack_seen;
      next_link_rdata = link_rdata;
      if (link_req && !link_busy) begin
         // New request only while idle; others are dropped
         next_held = link_cmd;
         next_req_tgl = ~req_tgl;
         next_busy = 1'b1;
      end else if (ack_s2 != ack_seen) begin
         next_ack_seen = ack_s2;
         next_busy = 1'b0;
         next_done = 1'b1;
         next_link_rdata = rdata_hold;
      end
   end

   always_ff @(posedge link_clk) begin
      lrst_meta <= resetn;
      lrst_n <= lrst_meta;
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
      if (!lrst_n) begin
         req_tgl <= 1'b0;
         link_busy <= 1'b0;
         held <= '0;
         link_done <= 1'b0;
         ack_seen <= 1'b0;
         link_rdata <= 8'h00;
      end else begin
         req_tgl <= next_req_tgl;
         link_busy <= next_busy;
         held <= next_held;
         link_done <= next_done;
         ack_seen <= next_ack_seen;
         link_rdata <= next_link_rdata;
      end
   end

   // ==========
   // Core domain
   logic next_strobe, next_req_seen, next_ack_tgl, next_capture;
   logic [7:0] next_rdata_hold;

   always_comb begin
      next_req_seen = req_seen;
      next_strobe = 1'b0;
      next_capture = core_strobe;
      next_ack_tgl = ack_tgl;
      next_rdata_hold = rdata_hold;
      if (req_s2 != req_seen) begin
         next_req_seen = req_s2;
         next_strobe = 1'b1;
      end
      if (capture) begin
         next_ack_tgl = ~ack_tgl;
      end
      if (core_strobe) begin
         next_rdata_hold = core_rdata;
      end
   end

   always_ff @(posedge core_clk) begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      // Held command is stable until the answer returns, so no resync needed
      core_cmd <= held;
      if (!resetn) begin
         req_seen <= 1'b0;
         core_strobe <= 1'b0;
         capture <= 1'b0;
         ack_tgl <= 1'b0;
         rdata_hold <= 8'h00;
      end else begin
         req_seen <= next_req_seen;
         core_strobe <= next_strobe;
         capture <= next_capture;
         ack_tgl <= next_ack_tgl;
         rdata_hold <= next_rdata_hold;
      end
   end
endmodule

// >>> logic/remote_sensor_config_regs.sv
// Purpose: configuration bank and remote result path of a temperature monitor
// Assumes: limit compare and bus protocol engine sit outside
// Notes: ideality scaling uses a reciprocal multiply, error under one LSB
`timescale 1ns/1ns

// Summary of operation
// - Alert-count bit 7 enables the bus time-out when one; it resets to zero.
// - Bits 3 to 1 set the out-of-limit run that raises the alert: 0h one, 1h two, 3h three, 7h four.
// - The ideality register at 23h reads back what was written and is taken as a signed byte, -128 to 127.
// - Remote results use an ideality of 1.008 times 2088 over 2088 plus the signed adjustment.
// - The ideality register resets to 00h, so the nominal factor applies.
// - Only remote results are scaled; local results pass untouched.
// - The remote channel applies a low then a high excitation current and uses the voltage difference.
// - Filter bits 1 to 0 select averaging of remote results: 0h none, 1h four, 2h eight.
// - Reading pointer FEh returns the fixed maker code; that register cannot be written.
module remote_sensor_config_regs
   import sensor_cfg_pkg::*;
#(
   parameter logic [7:0] MAKER_CODE = 8'hA5, // Arbitrary value
   parameter int DATA_W = 16
)(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic link_clk,
   input wire logic link_req,
   input wire logic link_write,
   input wire logic [7:0] link_ptr,
   input wire logic [7:0] link_wdata,
   output logic [7:0] link_rdata,
   output logic link_done,
   output logic link_busy,
   input wire logic conv_start,
   input wire logic adc_valid,
   input wire logic [DATA_W-1:0] adc_code,
   output logic excite_on,
   output logic excite_high,
   input wire logic local_valid,
   input wire logic [DATA_W-1:0] local_code,
   output logic [DATA_W-1:0] local_temp,
   output logic local_temp_valid,
   output logic [DATA_W-1:0] remote_temp,
   output logic remote_temp_valid,
   input wire logic limit_valid,
   input wire logic out_of_limit,
   output logic alert_flag,
   output logic alert_pin_oe,
   output logic bus_timeout_enable
);
   // ==========
   // Register access
   logic core_strobe;
   reg_req_s core_cmd;
   logic [7:0] read_value;
   logic [7:0] alert_count_and_timeout, ideality_adjust, remote_filter_control;
   logic [7:0] next_alert_reg, next_ideality, next_filter;
   reg_req_s link_cmd;

   assign link_cmd = '{write: link_write, ptr: link_ptr, wdata: link_wdata};

   link_reg_bridge bridge (
      .core_clk(core_clk),
      .resetn(resetn),
      .link_clk(link_clk),
      .link_req(link_req),
      .link_cmd(link_cmd),
      .link_rdata(link_rdata),
      .link_done(link_done),
      .link_busy(link_busy),
      .core_strobe(core_strobe),
      .core_cmd(core_cmd),
      .core_rdata(read_value)
   );

   always_comb begin
      case (core_cmd.ptr)
         PTR_ALERT_COUNT: read_value = alert_count_and_timeout;
         PTR_IDEALITY: read_value = ideality_adjust;
         PTR_FILTER: read_value = remote_filter_control;
         PTR_MAKER: read_value = MAKER_CODE;
         default: read_value = READ_UNMAPPED;
      endcase
   end

   always_comb begin
      next_alert_reg = alert_count_and_timeout;
      next_ideality = ideality_adjust;
      next_filter = remote_filter_control;
      // Maker pointer and unmapped pointers fall through untouched
      if (core_strobe && core_cmd.write) begin
         case (core_cmd.ptr)
            PTR_ALERT_COUNT: begin
               next_alert_reg = (alert_count_and_timeout & ~ALERT_COUNT_WMASK)
                              | (core_cmd.wdata & ALERT_COUNT_WMASK);
            end
            PTR_IDEALITY: next_ideality = core_cmd.wdata;
            PTR_FILTER: begin
               next_filter = (remote_filter_control & ~FILTER_WMASK) | (core_cmd.wdata & FILTER_WMASK);
            end
            default: next_ideality = ideality_adjust;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         alert_count_and_timeout <= RST_ALERT_COUNT;
         ideality_adjust <= RST_IDEALITY;
         remote_filter_control <= RST_FILTER;
      end else begin
         alert_count_and_timeout <= next_alert_reg;
         ideality_adjust <= next_ideality;
         remote_filter_control <= next_filter;
      end
   end

   // ==========
   // Time-out enable and consecutive alert counting
   logic [2:0] count_code;
   logic [2:0] required;
   logic [2:0] run_len, next_run_len;
   logic next_alert, next_timeout;

   assign count_code = alert_count_and_timeout[COUNT_MSB:COUNT_LSB];
   // Count of set bits plus one: 0h->1, 1h->2, 3h->3, 7h->4
   assign required = 3'(count_code[0]) + 3'(count_code[1]) + 3'(count_code[2]) + 3'h1;

   always_comb begin
      next_run_len = run_len;
      next_alert = alert_flag;
      next_timeout = alert_count_and_timeout[TIMEOUT_BIT];
      if (limit_valid) begin
         if (out_of_limit) begin
            // Saturate so a long excursion never wraps the count
            if (run_len < required) begin
               next_run_len = run_len + 3'h1;
            end
            next_alert = (run_len + 3'h1 >= required);
         end else begin
            next_run_len = 3'h0;
            next_alert = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         run_len <= 3'h0;
         alert_flag <= 1'b0;
         alert_pin_oe <= 1'b0;
         bus_timeout_enable <= 1'b0;
      end else begin
         run_len <= next_run_len;
         alert_flag <= next_alert;
         alert_pin_oe <= next_alert;
         bus_timeout_enable <= next_timeout;
      end
   end

   // ==========
   // Local channel passes straight through
   logic [DATA_W-1:0] next_local_temp;

   always_comb begin
      next_local_temp = local_valid ? local_code : local_temp;
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         local_temp <= '0;
         local_temp_valid <= 1'b0;
      end else begin
         local_temp_valid <= local_valid;
         local_temp <= next_local_temp;
      end
   end

   // ==========
   // Remote excitation sequence, ideality scaling and averaging
   localparam int PROD_W = DATA_W + 12;
   localparam int WIDE_W = PROD_W + 13;
   localparam int ACC_W = DATA_W + 4;
   seq_state_e state, next_state;
   logic [7:0] settle, next_settle;
   logic [DATA_W-1:0] v_low, next_v_low, delta, next_delta;
   logic [PROD_W-1:0] scaled, next_scaled;
   logic [DATA_W-1:0] corrected, next_corrected;
   logic [ACC_W-1:0] acc, next_acc;
   logic [3:0] avg_cnt, next_avg_cnt;
   logic [3:0] depth;
   logic [11:0] divisor;
   logic [WIDE_W-1:0] wide;
   logic [ACC_W-1:0] acc_sum;
   logic next_excite_on, next_excite_high, next_remote_valid;
   logic [DATA_W-1:0] next_remote_temp;

   // Signed adjustment widened and added to the base
   assign divisor = IDEALITY_BASE + {{4{ideality_adjust[7]}}, ideality_adjust};
   assign wide = WIDE_W'(scaled) * WIDE_W'(IDEALITY_RECIP);
   assign acc_sum = acc + ACC_W'(corrected);

   always_comb begin
      case (remote_filter_control[FILTER_MSB:0])
         AVG_FOUR: depth = DEPTH_FOUR;
         AVG_EIGHT: depth = DEPTH_EIGHT;
         default: depth = 4'h1;
      endcase
   end

   always_comb begin
      next_state = state;
      next_settle = settle;
      next_v_low = v_low;
      next_delta = delta;
      next_scaled = scaled;
      next_corrected = corrected;
      next_acc = acc;
      next_avg_cnt = avg_cnt;
      next_excite_on = excite_on;
      next_excite_high = excite_high;
      next_remote_valid = 1'b0;
      next_remote_temp = remote_temp;
      case (state)
         SEQ_IDLE: begin
            if (conv_start) begin
               next_state = SEQ_LOW;
               next_excite_on = 1'b1;
               next_excite_high = 1'b0;
               next_settle = 8'(SETTLE_CYCLES);
            end
         end
         SEQ_LOW: begin
            // Samples taken before the current settles are discarded
            if (settle != 8'h00) begin
               next_settle = settle - 8'h01;
            end else if (adc_valid) begin
               next_v_low = adc_code;
               next_excite_high = 1'b1;
               next_settle = 8'(SETTLE_CYCLES);
               next_state = SEQ_HIGH;
            end
         end
         SEQ_HIGH: begin
            if (settle != 8'h00) begin
               next_settle = settle - 8'h01;
            end else if (adc_valid) begin
               // Negative difference means a faulty junction; clamp to zero
               next_delta = (adc_code > v_low) ? adc_code - v_low : '0;
               next_excite_on = 1'b0;
               next_excite_high = 1'b0;
               next_state = SEQ_SCALE;
            end
         end
         SEQ_SCALE: begin
            next_scaled = PROD_W'(delta) * PROD_W'(divisor);
            next_state = SEQ_DIV;
         end
         SEQ_DIV: begin
            next_corrected = wide[RECIP_SHIFT +: DATA_W];
            next_state = SEQ_AVG;
         end
         SEQ_AVG: begin
            next_state = SEQ_IDLE;
            if (avg_cnt + 4'h1 >= depth) begin
               next_avg_cnt = 4'h0;
               next_acc = '0;
               next_remote_valid = 1'b1;
               if (depth == DEPTH_EIGHT) begin
                  next_remote_temp = DATA_W'(acc_sum >> SHIFT_EIGHT);
               end else if (depth == DEPTH_FOUR) begin
                  next_remote_temp = DATA_W'(acc_sum >> SHIFT_FOUR);
               end else begin
                  next_remote_temp = corrected;
               end
            end else begin
               next_avg_cnt = avg_cnt + 4'h1;
               next_acc = acc_sum;
            end
         end
         default: begin
            next_state = SEQ_IDLE;
            next_excite_on = 1'b0;
            next_excite_high = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         state <= SEQ_IDLE;
         settle <= 8'h00;
         v_low <= '0;
         delta <= '0;
         scaled <= '0;
         corrected <= '0;
         acc <= '0;
         avg_cnt <= 4'h0;
         excite_on <= 1'b0;
         excite_high <= 1'b0;
         remote_temp_valid <= 1'b0;
         remote_temp <= '0;
      end else begin
         state <= next_state;
         settle <= next_settle;
         v_low <= next_v_low;
         delta <= next_delta;
         scaled <= next_scaled;
         corrected <= next_corrected;
         acc <= next_acc;
         avg_cnt <= next_avg_cnt;
         excite_on <= next_excite_on;
         excite_high <= next_excite_high;
         remote_temp_valid <= next_remote_valid;
         remote_temp <= next_remote_temp;
      end
   end
endmodule

// >>> tb/sensor_cfg_monitor.sv
// Purpose: port checks of the sensor configuration bank
// Assumes: bound into the top module
// Notes: link checks keep a copy of the accepted request
`timescale 1ns/1ns
module sensor_cfg_monitor
   import sensor_cfg_pkg::*;
#(
   parameter logic [7:0] MAKER_CODE = 8'hA5, // Arbitrary value
   parameter int DATA_W = 16
)(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic link_clk,
   input wire logic link_req,
   input wire logic link_write,
   input wire logic [7:0] link_ptr,
   input wire logic [7:0] link_rdata,
   input wire logic link_done,
   input wire logic link_busy,
   input wire logic conv_start,
   input wire logic adc_valid,
   input wire logic excite_on,
   input wire logic excite_high,
   input wire logic local_valid,
   input wire logic [DATA_W-1:0] local_code,
   input wire logic [DATA_W-1:0] local_temp,
   input wire logic local_temp_valid,
   input wire logic limit_valid,
   input wire logic out_of_limit,
   input wire logic alert_flag,
   input wire logic alert_pin_oe,
   input wire logic bus_timeout_enable
);
   // ==========
   // Request copy, so a read is judged when its answer returns
   logic take, rd_ok, next_rd_ok;
   logic [7:0] ptr_q, next_ptr_q;
   assign take = link_req && !link_busy;
   always_comb begin
      next_ptr_q = take ? link_ptr : ptr_q;
      next_rd_ok = take ? !link_write : rd_ok;
   end
   always_ff @(posedge link_clk) begin
      ptr_q <= next_ptr_q;
      rd_ok <= next_rd_ok;
   end
   // ==========
   // Assertions
   a_maker_read: assert property (@(posedge link_clk) disable iff (!resetn)
      link_done && rd_ok && ptr_q == PTR_MAKER |-> link_rdata == MAKER_CODE) else $error("maker code wrong");
   a_filter_reserved: assert property (@(posedge link_clk) disable iff (!resetn)
      link_done && rd_ok && ptr_q == PTR_FILTER |-> link_rdata[7:2] == 6'h00) else $error("filter spare bits set");
   a_timeout_copy: assert property (@(posedge link_clk) disable iff (!resetn)
      link_done && rd_ok && ptr_q == PTR_ALERT_COUNT |-> link_rdata[TIMEOUT_BIT] == bus_timeout_enable)
      else $error("time-out enable differs");
   a_access_ends: assert property (@(posedge link_clk) disable iff (!resetn)
      take |=> link_busy ##[1:20] link_done) else $error("access did not finish");
   a_local_untouched: assert property (@(posedge core_clk) disable iff (!resetn)
      local_valid |=> local_temp_valid && local_temp == $past(local_code)) else $error("local result altered");
   a_low_first: assert property (@(posedge core_clk) disable iff (!resetn)
      $rose(excite_on) |-> !excite_high && $past(conv_start)) else $error("excitation not low first");
   a_high_after_sample: assert property (@(posedge core_clk) disable iff (!resetn)
      $rose(excite_high) |-> excite_on && $past(adc_valid)) else $error("high current too early");
   a_pin_follows_flag: assert property (@(posedge core_clk) disable iff (!resetn)
      alert_pin_oe == alert_flag) else $error("alert pin differs from flag");
   a_inlimit_clears: assert property (@(posedge core_clk) disable iff (!resetn)
      limit_valid && !out_of_limit |=> !alert_flag) else $error("alert kept after in-limit");
   a_alert_cause: assert property (@(posedge core_clk) disable iff (!resetn)
      $rose(alert_flag) |-> $past(limit_valid && out_of_limit)) else $error("alert without cause");
   c_access: cover property (@(posedge link_clk) disable iff (!resetn) link_done);
   c_high: cover property (@(posedge core_clk) disable iff (!resetn) $rose(excite_high));
   c_alert: cover property (@(posedge core_clk) disable iff (!resetn) $rose(alert_flag));
endmodule

bind remote_sensor_config_regs sensor_cfg_monitor #(.MAKER_CODE(MAKER_CODE), .DATA_W(DATA_W)) u_sensor_cfg_monitor (
   .core_clk, .resetn, .link_clk, .link_req, .link_write, .link_ptr, .link_rdata, .link_done, .link_busy,
   .conv_start, .adc_valid, .excite_on, .excite_high, .local_valid, .local_code, .local_temp,
   .local_temp_valid, .limit_valid, .out_of_limit, .alert_flag, .alert_pin_oe, .bus_timeout_enable);

// >>> tb/link_host_model.sv
// Purpose: register host on the link side of the configuration bank
// Assumes: one access at a time, link clock free-running
// Notes: released lines carry the inverse, so stale data never matches
`timescale 1ns/1ns
module link_host_model
   import sensor_cfg_pkg::*;
(
   input wire logic link_clk,
   input wire logic link_busy,
   input wire logic link_done,
   input wire logic [7:0] link_rdata,
   output logic link_req,
   output reg_req_s cmd
);
   initial begin
      link_req = 1'b0;
      cmd = '0;
   end
   // A lost answer leaves rd unknown, which every comparison rejects
   task automatic access(input logic wr, input logic [7:0] ptr, input logic [7:0] wd, output logic [7:0] rd);
      int n;
      rd = 8'hXX;
      @(posedge link_clk);
      for (n = 0; n < 40 && link_busy !== 1'b0; n++) @(posedge link_clk);
      #1;
      link_req = 1'b1;
      cmd = '{write: wr, ptr: ptr, wdata: wd};
      @(posedge link_clk);
      #1;
      link_req = 1'b0;
      cmd = reg_req_s'(~cmd);
      for (n = 0; n < 40; n++) begin
         @(posedge link_clk);
         if (link_done === 1'b1) begin
            rd = link_rdata;
            break;
         end
      end
   endtask
endmodule

// >>> tb/remote_sensor_config_regs_tb.sv
// Purpose: self-checking bench of the sensor configuration bank
// Assumes: host model on the link side, bench drives the core side
// Notes: sample waits use the fixed ten-cycle excitation settle
`timescale 1ns/1ns
module remote_sensor_config_regs_tb
   import sensor_cfg_pkg::*;
;
   localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value
   localparam int TIME_LIMIT = 20000;
   typedef struct packed {logic wr; logic [7:0] ptr; logic [7:0] wd; logic [7:0] rd; logic to;} row_s;
   // Access, answer expected, time-out enable after it
   row_s rows [18] = '{
      '{'0, 8'h22, '0, 8'h01, '0}, '{'0, 8'h23, '0, 8'h00, '0}, '{'0, 8'h24, '0, 8'h00, '0},
      '{'0, 8'hFE, '0, MAKER, '0}, '{'0, 8'h30, '0, READ_UNMAPPED, '0}, '{'1, 8'h22, 8'hFF, 8'h01, '1},
      '{'0, 8'h22, '0, 8'h8F, '1}, '{'1, 8'h22, 8'h7E, 8'h8F, '0}, '{'0, 8'h22, '0, 8'h0F, '0},
      '{'1, 8'h23, 8'h80, 8'h00, '0}, '{'0, 8'h23, '0, 8'h80, '0}, '{'1, 8'h23, 8'h7F, 8'h80, '0},
      '{'0, 8'h23, '0, 8'h7F, '0}, '{'1, 8'h24, 8'hFE, 8'h00, '0}, '{'0, 8'h24, '0, 8'h02, '0},
      '{'1, 8'hFE, 8'h00, MAKER, '0}, '{'0, 8'hFE, '0, MAKER, '0}, '{'0, 8'h22, '0, 8'h0F, '0}};
   logic [7:0] cv_adj [5] = '{8'h00, 8'h7F, 8'h80, 8'h0A, 8'hF6};
   logic [7:0] cv_flt [5] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
   logic [15:0] cv_lo [5] = '{16'h0064, 16'h00C8, 16'h0000, 16'h0384, 16'h0032};
   logic [15:0] cv_hi [5] = '{16'h044C, 16'h04B0, 16'h0BB8, 16'h01F4, 16'h0802};
   logic core_clk = 1'b1, link_clk = 1'b0, resetn = 1'b0;
   logic conv_start = 1'b0, adc_valid = 1'b0, local_valid = 1'b0, limit_valid = 1'b0, out_of_limit = 1'b0;
   logic [15:0] adc_code = 16'h0000, local_code = 16'h0000;
   logic link_req, link_done, link_busy, excite_on, excite_high, local_temp_valid, remote_temp_valid;
   logic alert_flag, alert_pin_oe, bus_timeout_enable;
   logic [7:0] link_rdata;
   logic [15:0] local_temp, remote_temp;
   reg_req_s cmd;
   int n_fail = 0, checks = 0, cycles = 0;
   remote_sensor_config_regs #(.MAKER_CODE(MAKER), .DATA_W(16)) u_remote_sensor_config_regs (
      .core_clk, .resetn, .link_clk, .link_req, .link_write(cmd.write), .link_ptr(cmd.ptr),
      .link_wdata(cmd.wdata), .link_rdata, .link_done, .link_busy, .conv_start, .adc_valid, .adc_code,
      .excite_on, .excite_high, .local_valid, .local_code, .local_temp, .local_temp_valid, .remote_temp,
      .remote_temp_valid, .limit_valid, .out_of_limit, .alert_flag, .alert_pin_oe, .bus_timeout_enable);
   link_host_model u_link_host_model (.link_clk, .link_busy, .link_done, .link_rdata, .link_req, .cmd);
   always #5 core_clk = ~core_clk;
   always #15 link_clk = ~link_clk;
   // ==========
   // Helpers
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == TIME_LIMIT) begin
         n_fail++;
         tally_and_finish();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // Long enough for the link side too, which resyncs reset
   task automatic do_reset();
      resetn = 1'b0;
      repeat (6) @(posedge link_clk);
      tick(1);
      resetn = 1'b1;
      tick(12);
   endtask
   task automatic verdict(input logic out, output logic a);
      limit_valid = 1'b1;
      out_of_limit = out;
      tick(1);
      a = alert_flag;
      limit_valid = 1'b0;
      tick(1);
   endtask
   task automatic convert(input logic [15:0] lo, input logic [15:0] hi, output logic got, output logic [15:0] res);
      int n, p;
      got = 1'b0;
      res = 16'hXXXX;
      conv_start = 1'b1;
      tick(1);
      conv_start = 1'b0;
      for (p = 0; p < 2; p++) begin
         for (n = 0; n < 5 && !(excite_on === 1'b1 && excite_high === 1'(p)); n++) tick(1);
         tick(SETTLE_CYCLES + 2);
         adc_valid = 1'b1;
         adc_code = p ? hi : lo;
         tick(1);
         adc_valid = 1'b0;
         adc_code = ~adc_code;
      end
      for (n = 0; n < 10 && !got; n++) begin
         tick(1);
         got = (remote_temp_valid === 1'b1);
         res = got ? remote_temp : res;
      end
      tick(4);
   endtask
   function automatic logic [15:0] scaled(input logic [15:0] lo, input logic [15:0] hi, input logic [7:0] adj);
      longint d;
      d = (hi > lo) ? longint'(hi - lo) : longint'(16'h0000);
      return 16'((d * (longint'(IDEALITY_BASE) + longint'($signed(adj))) * longint'(IDEALITY_RECIP)) >> RECIP_SHIFT);
   endfunction
   // ==========
   // Tests
   initial begin
      logic [7:0] rd;
      logic a, got;
      logic [15:0] res, sum;
      int i, j;
      do_reset();
      for (i = 0; i < 18; i++) begin
         u_link_host_model.access(rows[i].wr, rows[i].ptr, rows[i].wd, rd);
         tick(2);
         check("register answer", 16'(rd), 16'(rows[i].rd));
         check("time-out enable", 16'(bus_timeout_enable), 16'(rows[i].to));
      end
      $display("test register rows done");
      do_reset();
      u_link_host_model.access(1'b0, PTR_IDEALITY, 8'h00, rd);
      check("ideality after reset", 16'(rd), 16'(RST_IDEALITY));
      u_link_host_model.access(1'b0, PTR_MAKER, 8'h00, rd);
      check("maker code", 16'(rd), 16'(MAKER));
      $display("test second reset done");
      for (i = 0; i < 4; i++) begin
         u_link_host_model.access(1'b1, PTR_ALERT_COUNT, {4'h0, 3'((1 << i) - 1), 1'b0}, rd);
         for (j = 0; j <= i + 1; j++) begin
            verdict(1'b1, a);
            check("alert after run", 16'(a), 16'(j >= i));
         end
         verdict(1'b0, a);
         check("alert cleared", 16'(a), 16'h0000);
      end
      $display("test alert count done");
      for (i = 0; i < 5; i++) begin
         u_link_host_model.access(1'b1, PTR_IDEALITY, cv_adj[i], rd);
         u_link_host_model.access(1'b1, PTR_FILTER, cv_flt[i], rd);
         convert(cv_lo[i], cv_hi[i], got, res);
         check("remote valid", 16'(got), 16'h0001);
         check("remote result", res, scaled(cv_lo[i], cv_hi[i], cv_adj[i]));
      end
      local_valid = 1'b1;
      local_code = 16'hBEEF;
      tick(1);
      local_valid = 1'b0;
      local_code = 16'h4110;
      check("local copy", local_temp, 16'hBEEF);
      $display("test conversion done");
      for (i = 1; i < 3; i++) begin
         u_link_host_model.access(1'b1, PTR_FILTER, 8'(i), rd);
         sum = 16'h0000;
         for (j = 0; j < (4 << (i - 1)); j++) begin
            convert(16'h0010, 16'(16'h0100 + 50 * j), got, res);
            sum = sum + scaled(16'h0010, 16'(16'h0100 + 50 * j), 8'hF6);
            check("average held back", 16'(got), 16'(j == (4 << (i - 1)) - 1));
         end
         check("average", res, sum >> (i + 1));
      end
      $display("test averaging done");
      tally_and_finish();
   end
endmodule
